//--- flpb_cfg.svh
// Constants of the parallel flash pin controller
// How it works
// - Sync mode: address taken at address-valid rise or first clock edge while low.
// - Async mode: address flows while address-valid low, held from its rise.
// - Die select high deselects the die and floats data and wait.
// - Data driven on reads only while output enable low; high floats data, wait.
// - Reset pin low clears the write automation and ignores every write.
// - Leaving reset puts the device in asynchronous read-array mode.
// - Asserted level of wait follows bit 10 of the read configuration register.
// - Synchronous burst reads assert wait while data invalid, deassert when valid.
// - Async page reads and all writes keep wait deasserted.
// - Address and write data are captured at the write strobe rising edge.
// - Write-protect low: lock-down active, unlock cannot free locked-down blocks.
// - Write-protect high overrides lock-down so software may program blocks.
// - Data bus takes commands on writes, returns array, status or config on reads.
`ifndef FLPB_CFG_SVH
`define FLPB_CFG_SVH

// ==========================================================
// Sizes
`define FLPB_ADDR_W 8
`define FLPB_DATA_W 16
`define FLPB_BLK_W 2

// ==========================================================
// Read configuration register layout
`define FLPB_CFG_RST 16'h8400
`define FLPB_CFG_ASYNC_BIT 15
`define FLPB_CFG_WAIT_BIT 10
`define FLPB_CFG_LAT_MSB 13
`define FLPB_CFG_LAT_LSB 11

// ==========================================================
// Status word layout
`define FLPB_STAT_READY_BIT 7
`define FLPB_STAT_PROG_ERR_BIT 4
`define FLPB_STAT_LOCK_ERR_BIT 1

// ==========================================================
// Commands, low byte of a write
`define FLPB_CMD_READ_ARRAY 8'hff
`define FLPB_CMD_READ_STATUS 8'h70
`define FLPB_CMD_READ_CONFIG 8'h90
`define FLPB_CMD_CLEAR_STATUS 8'h50
`define FLPB_CMD_SET_CONFIG 8'h60
`define FLPB_CMD_PROGRAM 8'h40
`define FLPB_CMD_LOCK 8'h01
`define FLPB_CMD_LOCK_DOWN 8'h2f
`define FLPB_CMD_UNLOCK 8'hd0

// ==========================================================
// Timing and reset values
`define FLPB_CLK_PERIOD_NS 8
`define FLPB_PROG_TIME_NS 200
`define FLPB_PROG_CYCLES ((`FLPB_PROG_TIME_NS + `FLPB_CLK_PERIOD_NS - 1) / `FLPB_CLK_PERIOD_NS)
`define FLPB_LOCK_RST 1'b1

`endif

//--- flpb_pkg.sv
// Types of the parallel flash pin controller
package flpb_pkg;

    typedef enum logic [1:0] {
        FLPB_RD_ARRAY  = 2'b00,
        FLPB_RD_STATUS = 2'b01,
        FLPB_RD_CONFIG = 2'b10
    } flpb_rmode_t;

    typedef enum logic [1:0] {
        FLPB_W_IDLE = 2'b00,
        FLPB_W_CFG  = 2'b01,
        FLPB_W_DATA = 2'b10
    } flpb_wstate_t;

endpackage : flpb_pkg

//--- flpb_xfer_if.sv
// Address word carried from the link clock domain to the core
`timescale 1ns/100ps
interface flpb_xfer_if #(
    parameter int ADDR_W = 8
);
    logic [ADDR_W-1:0] addr;
    logic              tgl;

    modport link (output addr, output tgl);
    modport core (input addr, input tgl);
endinterface : flpb_xfer_if

//--- flpb_link.sv
// Link-clock capture of the burst start address
`timescale 1ns/100ps
`include "flpb_cfg.svh"
module flpb_link #(
    parameter int ADDR_W = `FLPB_ADDR_W
) (
    input  wire logic              link_clk_i,
    input  wire logic              rst_i,
    input  wire logic              address_valid_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    flpb_xfer_if.link              xfer
);
    logic              armed_q;
    logic              tgl_q;
    logic [ADDR_W-1:0] addr_q;

    // ==========================================================
    // Capture
    // Pins are synchronous to the host clock, so they are sampled directly.
    // A low period shorter than one link edge is caught by the core instead.
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            armed_q <= 1'b1;
            tgl_q   <= 1'b0;
            addr_q  <= '0;
        end else if (address_valid_n_i) begin
            armed_q <= 1'b1;
        end else if (armed_q) begin
            addr_q  <= addr_i;
            tgl_q   <= ~tgl_q;
            armed_q <= 1'b0;
        end
    end

    assign xfer.addr = addr_q;
    assign xfer.tgl  = tgl_q;

    AST_LINK_FIRST_EDGE: assert property (@(posedge link_clk_i) disable iff (rst_i)
        (!address_valid_n_i && armed_q) |=> (addr_q == $past(addr_i)) && $changed(tgl_q))
        else $error("link did not capture address at first edge with address valid low");

endmodule : flpb_link

//--- flpb_top.sv
// Parallel flash pin controller: pin sampling, address latch, command engine, drivers
`timescale 1ns/100ps
`include "flpb_cfg.svh"
module flpb_top #(
    parameter int ADDR_W = `FLPB_ADDR_W,
    parameter int DATA_W = `FLPB_DATA_W,
    parameter int BLK_W  = `FLPB_BLK_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              link_clk_i,
    input  wire logic              pin_reset_n_i,
    input  wire logic              address_valid_n_i,
    input  wire logic              die_select_n_i,
    input  wire logic              die_output_enable_n_i,
    input  wire logic              write_strobe_n_i,
    input  wire logic              write_protect_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe_o,
    output logic                   wait_o,
    output logic                   wait_oe_o
);
    localparam int PW     = 6 + ADDR_W + DATA_W;
    localparam int NBLK   = 2 ** BLK_W;
    localparam int AD_LSB = DATA_W;
    localparam int AVL_B  = ADDR_W + DATA_W;
    localparam int CE_B   = AVL_B + 1;
    localparam int OE_B   = AVL_B + 2;
    localparam int WE_B   = AVL_B + 3;
    localparam int WP_B   = AVL_B + 4;
    localparam int RST_B  = AVL_B + 5;
    localparam int LAT_W  = `FLPB_CFG_LAT_MSB - `FLPB_CFG_LAT_LSB + 1;
    localparam logic [7:0] PROG_CYC = 8'(`FLPB_PROG_CYCLES);
    localparam logic [PW-1:0] PIN_IDLE = {6'h3f, {(ADDR_W + DATA_W){1'b0}}};

    // ==========================================================
    // Pin synchronisers
    logic [PW-1:0] pin_meta_q;
    logic [PW-1:0] pin_now_q;
    logic [PW-1:0] pin_prev_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_meta_q <= PIN_IDLE;
            pin_now_q  <= PIN_IDLE;
            pin_prev_q <= PIN_IDLE;
        end else begin
            pin_meta_q <= {pin_reset_n_i, write_protect_n_i, write_strobe_n_i,
                           die_output_enable_n_i, die_select_n_i, address_valid_n_i,
                           addr_i, dq_i};
            pin_now_q  <= pin_meta_q;
            pin_prev_q <= pin_now_q;
        end
    end

    logic              rst_pin;
    logic              wp_n_s;
    logic              we_n_s;
    logic              oe_n_s;
    logic              ce_n_s;
    logic              avl_n_s;
    logic              avl_n_p;
    logic              we_n_p;
    logic              ce_n_p;
    logic [ADDR_W-1:0] addr_s;
    logic [ADDR_W-1:0] addr_p;
    logic [DATA_W-1:0] dq_p;

    assign rst_pin = ~pin_now_q[RST_B];
    assign wp_n_s  = pin_now_q[WP_B];
    assign we_n_s  = pin_now_q[WE_B];
    assign oe_n_s  = pin_now_q[OE_B];
    assign ce_n_s  = pin_now_q[CE_B];
    assign avl_n_s = pin_now_q[AVL_B];
    assign addr_s  = pin_now_q[AD_LSB +: ADDR_W];
    assign avl_n_p = pin_prev_q[AVL_B];
    assign we_n_p  = pin_prev_q[WE_B];
    assign ce_n_p  = pin_prev_q[CE_B];
    assign addr_p  = pin_prev_q[AD_LSB +: ADDR_W];
    assign dq_p    = pin_prev_q[DATA_W-1:0];

    // ==========================================================
    // Link domain and its crossing
    flpb_xfer_if #(.ADDR_W(ADDR_W)) xfer ();

    flpb_link #(.ADDR_W(ADDR_W)) u_link (
        .link_clk_i        (link_clk_i),
        .rst_i             (rst_i),
        .address_valid_n_i (address_valid_n_i),
        .addr_i            (addr_i),
        .xfer              (xfer.link)
    );

    logic tgl_meta_q;
    logic tgl_now_q;
    logic tgl_prev_q;
    logic link_evt;

    // The word is held long before its toggle has crossed, so it is read directly
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tgl_meta_q <= 1'b0;
            tgl_now_q  <= 1'b0;
            tgl_prev_q <= 1'b0;
        end else begin
            tgl_meta_q <= xfer.tgl;
            tgl_now_q  <= tgl_meta_q;
            tgl_prev_q <= tgl_now_q;
        end
    end

    assign link_evt = tgl_now_q ^ tgl_prev_q;

    // ==========================================================
    // Address latch
    logic [DATA_W-1:0] cfg_q;
    logic [ADDR_W-1:0] addr_q;
    logic              taken_q;
    logic              async_mode;
    logic              avl_rise;
    logic              avl_fall;
    logic              sync_take;

    assign async_mode = cfg_q[`FLPB_CFG_ASYNC_BIT];
    assign avl_rise   = avl_n_s && !avl_n_p;
    assign avl_fall   = !avl_n_s && avl_n_p;
    assign sync_take  = !async_mode && !taken_q && (avl_rise || (!avl_n_s && link_evt));

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_q  <= '0;
            taken_q <= 1'b0;
        end else if (async_mode) begin
            taken_q <= 1'b0;
            if (!avl_n_s) begin
                addr_q <= addr_s;
            end
        end else begin
            if (avl_rise && !taken_q) begin
                addr_q <= addr_p;
            end else if (sync_take) begin
                addr_q <= xfer.addr;
            end
            if (avl_fall) begin
                taken_q <= 1'b0;
            end else if (sync_take) begin
                taken_q <= 1'b1;
            end
        end
    end

    AST_ASYNC_FLOW: assert property (@(posedge clk_i) disable iff (rst_i)
        (async_mode && !avl_n_s) |=> (addr_q == $past(addr_s)))
        else $error("address did not flow through in asynchronous mode");

    AST_ASYNC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        (async_mode && avl_n_s && $past(avl_n_s) && $stable(cfg_q)) |-> $stable(addr_q))
        else $error("address changed while address valid stayed high");

    AST_SYNC_RISE: assert property (@(posedge clk_i) disable iff (rst_i)
        (!async_mode && avl_rise && !taken_q) |=> (addr_q == $past(addr_p)) && taken_q)
        else $error("sync address not taken at address valid rise");

    // ==========================================================
    // Command engine and lock bits
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic [NBLK-1:0]   locked_q;
    logic [NBLK-1:0]   lockdown_q;
    logic [7:0]        busy_q;
    logic              prog_err_q;
    logic              lock_err_q;
    logic              wr_go;
    logic              mem_we;
    logic [BLK_W-1:0]  wr_blk;
    logic [7:0]        wr_cmd;
    flpb_pkg::flpb_rmode_t  rmode_q;
    flpb_pkg::flpb_wstate_t wstate_q;

    // Write taken one sample after the strobe rises, with the sample held low
    assign wr_go  = we_n_s && !we_n_p && !ce_n_p && !rst_pin && (busy_q == 8'h00);
    assign wr_blk = addr_p[ADDR_W-1 -: BLK_W];
    assign wr_cmd = dq_p[7:0];
    assign mem_we = wr_go && (wstate_q == flpb_pkg::FLPB_W_DATA) && !locked_q[wr_blk];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wstate_q   <= flpb_pkg::FLPB_W_IDLE;
            rmode_q    <= flpb_pkg::FLPB_RD_ARRAY;
            cfg_q      <= `FLPB_CFG_RST;
            busy_q     <= 8'h00;
            prog_err_q <= 1'b0;
            lock_err_q <= 1'b0;
        end else if (rst_pin) begin
            wstate_q   <= flpb_pkg::FLPB_W_IDLE;
            rmode_q    <= flpb_pkg::FLPB_RD_ARRAY;
            cfg_q      <= `FLPB_CFG_RST;
            busy_q     <= 8'h00;
            prog_err_q <= 1'b0;
            lock_err_q <= 1'b0;
        end else begin
            if (busy_q != 8'h00) begin
                busy_q <= busy_q - 8'h01;
            end
            if (wr_go) begin
                unique case (wstate_q)
                    flpb_pkg::FLPB_W_IDLE: begin
                        if (wr_cmd == `FLPB_CMD_READ_ARRAY) begin
                            rmode_q <= flpb_pkg::FLPB_RD_ARRAY;
                        end else if (wr_cmd == `FLPB_CMD_READ_STATUS) begin
                            rmode_q <= flpb_pkg::FLPB_RD_STATUS;
                        end else if (wr_cmd == `FLPB_CMD_READ_CONFIG) begin
                            rmode_q <= flpb_pkg::FLPB_RD_CONFIG;
                        end else if (wr_cmd == `FLPB_CMD_CLEAR_STATUS) begin
                            prog_err_q <= 1'b0;
                            lock_err_q <= 1'b0;
                        end else if (wr_cmd == `FLPB_CMD_SET_CONFIG) begin
                            wstate_q <= flpb_pkg::FLPB_W_CFG;
                        end else if (wr_cmd == `FLPB_CMD_PROGRAM) begin
                            wstate_q <= flpb_pkg::FLPB_W_DATA;
                        end else if (wr_cmd == `FLPB_CMD_UNLOCK) begin
                            if (lockdown_q[wr_blk] && !wp_n_s) begin
                                lock_err_q <= 1'b1;
                            end
                        end
                    end
                    flpb_pkg::FLPB_W_CFG: begin
                        cfg_q    <= dq_p;
                        wstate_q <= flpb_pkg::FLPB_W_IDLE;
                    end
                    flpb_pkg::FLPB_W_DATA: begin
                        if (locked_q[wr_blk]) begin
                            prog_err_q <= 1'b1;
                        end else begin
                            busy_q <= PROG_CYC;
                        end
                        rmode_q  <= flpb_pkg::FLPB_RD_STATUS;
                        wstate_q <= flpb_pkg::FLPB_W_IDLE;
                    end
                    default: begin
                        wstate_q <= flpb_pkg::FLPB_W_IDLE;
                    end
                endcase
            end
        end
    end

    // Lock-down survives only until the reset pin; it is what write-protect guards
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            locked_q   <= {NBLK{`FLPB_LOCK_RST}};
            lockdown_q <= '0;
        end else if (rst_pin) begin
            locked_q   <= {NBLK{`FLPB_LOCK_RST}};
            lockdown_q <= '0;
        end else if (wr_go && (wstate_q == flpb_pkg::FLPB_W_IDLE)) begin
            if (wr_cmd == `FLPB_CMD_LOCK) begin
                locked_q[wr_blk] <= 1'b1;
            end else if (wr_cmd == `FLPB_CMD_LOCK_DOWN) begin
                locked_q[wr_blk]   <= 1'b1;
                lockdown_q[wr_blk] <= 1'b1;
            end else if (wr_cmd == `FLPB_CMD_UNLOCK) begin
                if (!lockdown_q[wr_blk] || wp_n_s) begin
                    locked_q[wr_blk] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[addr_p] <= dq_p;
        end
    end

    AST_RESET_IGNORES_WRITES: assert property (@(posedge clk_i) disable iff (rst_i)
        rst_pin |-> !wr_go ##1 (wstate_q == flpb_pkg::FLPB_W_IDLE) && (busy_q == 8'h00))
        else $error("write accepted or automation kept during pin reset");

    AST_RESET_EXIT_MODE: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(rst_pin) |-> (rmode_q == flpb_pkg::FLPB_RD_ARRAY) && cfg_q[`FLPB_CFG_ASYNC_BIT])
        else $error("device not in asynchronous read-array mode after reset");

    AST_WE_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_go && wstate_q == flpb_pkg::FLPB_W_CFG) |=> (cfg_q == $past(dq_p)))
        else $error("write data not captured at write strobe rise");

    AST_LOCKDOWN_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_go && wstate_q == flpb_pkg::FLPB_W_IDLE && wr_cmd == `FLPB_CMD_UNLOCK
         && lockdown_q[wr_blk] && !wp_n_s) |=> locked_q[$past(wr_blk)] && lock_err_q)
        else $error("locked-down block was unlocked with write-protect low");

    AST_WP_OVERRIDE: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_go && wstate_q == flpb_pkg::FLPB_W_IDLE && wr_cmd == `FLPB_CMD_UNLOCK
         && wp_n_s) |=> !locked_q[$past(wr_blk)])
        else $error("write-protect high did not override lock-down");

    // ==========================================================
    // Read path, wait and drivers
    logic [LAT_W-1:0]  lat_q;
    logic              read_active;
    logic              wait_assert;
    logic              wait_level;
    logic [DATA_W-1:0] status_word;

    assign read_active = !ce_n_s && !oe_n_s && we_n_s;
    assign wait_level  = cfg_q[`FLPB_CFG_WAIT_BIT];
    // Wait counts core cycles, not link edges: a conservative stand-in for latency
    assign wait_assert = !async_mode && read_active && (lat_q != '0);

    always_comb begin
        status_word                          = '0;
        status_word[`FLPB_STAT_READY_BIT]    = (busy_q == 8'h00);
        status_word[`FLPB_STAT_PROG_ERR_BIT] = prog_err_q;
        status_word[`FLPB_STAT_LOCK_ERR_BIT] = lock_err_q;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lat_q <= '0;
        end else if (sync_take) begin
            lat_q <= cfg_q[`FLPB_CFG_LAT_MSB:`FLPB_CFG_LAT_LSB];
        end else if (lat_q != '0) begin
            lat_q <= lat_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_o <= '0;
        end else begin
            unique case (rmode_q)
                flpb_pkg::FLPB_RD_ARRAY:  dq_o <= mem[addr_q];
                flpb_pkg::FLPB_RD_STATUS: dq_o <= status_word;
                flpb_pkg::FLPB_RD_CONFIG: dq_o <= cfg_q;
                default:                  dq_o <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dq_oe_o   <= 1'b0;
            wait_oe_o <= 1'b0;
            wait_o    <= 1'b0;
        end else begin
            dq_oe_o   <= read_active;
            wait_oe_o <= !ce_n_s && !oe_n_s;
            wait_o    <= wait_assert ? wait_level : !wait_level;
        end
    end

    AST_DESELECT_FLOATS: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_n_s |=> !dq_oe_o && !wait_oe_o)
        else $error("outputs driven while die deselected");

    AST_OE_HIGH_FLOATS: assert property (@(posedge clk_i) disable iff (rst_i)
        (oe_n_s || !we_n_s) |=> !dq_oe_o)
        else $error("data driven outside a read cycle");

    AST_WAIT_INVALID: assert property (@(posedge clk_i) disable iff (rst_i)
        (!async_mode && read_active && lat_q != '0) |=> (wait_o == $past(wait_level)))
        else $error("wait not asserted while burst data invalid");

    AST_WAIT_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
        (async_mode || !we_n_s) |=> (wait_o != $past(wait_level)))
        else $error("wait asserted in asynchronous or write mode");

endmodule : flpb_top

//--- flpb_host.sv
// Host-side pin driver model for the parallel flash pin controller
`timescale 1ns/100ps
module flpb_host (
    input  wire logic        clk_i,
    input  wire logic [15:0] dev_dq_i,
    input  wire logic        dev_dq_oe_i,
    output logic             link_clk_o,
    output logic             pin_reset_n_o,
    output logic             address_valid_n_o,
    output logic             die_select_n_o,
    output logic             die_output_enable_n_o,
    output logic             write_strobe_n_o,
    output logic             write_protect_n_o,
    output logic [7:0]       addr_o,
    output logic [15:0]      dq_bus_o
);
    logic [15:0] h_dq;
    logic        h_oe;
    logic        lk_run;
    // A released bus shows the inverse of the last host value, never a held copy
    assign dq_bus_o = dev_dq_oe_i ? dev_dq_i : (h_oe ? h_dq : ~h_dq);
    initial begin
        {pin_reset_n_o, die_select_n_o, die_output_enable_n_o} = 3'h7;
        {write_strobe_n_o, write_protect_n_o} = 2'h3;
        address_valid_n_o = 1'b0;
        {addr_o, h_dq, h_oe, lk_run, link_clk_o} = '0;
    end
    // Link clock runs only inside read frames and always parks low;
    // its edges sit between core edges so they never race the pin changes
    initial begin
        #7;
        forever begin
            #24;
            if (lk_run || link_clk_o) link_clk_o = ~link_clk_o;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        // Deselect first so the device has let go of the data bus
        {die_select_n_o, die_output_enable_n_o} = 2'h3;
        repeat (4) @(negedge clk_i);
        {die_select_n_o, write_strobe_n_o, addr_o, h_dq, h_oe} = {2'h0, a, d, 1'b1};
        repeat (4) @(negedge clk_i);
        write_strobe_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        {die_select_n_o, h_oe} = 2'h2;
        repeat (3) @(negedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic oe_n);
        @(negedge clk_i);
        {die_select_n_o, die_output_enable_n_o, addr_o} = {1'b0, oe_n, a};
        repeat (8) @(negedge clk_i);
    endtask : rd
endmodule : flpb_host

//--- flash_parallel_bus_pins_bench.sv
// Self-checking bench for the parallel flash pin controller
`timescale 1ns/100ps
`include "flpb_cfg.svh"
module flash_parallel_bus_pins_bench;
    localparam logic [15:0] CFG0 = `FLPB_CFG_RST;
    localparam logic [15:0] RDY  = 16'h1 << `FLPB_STAT_READY_BIT;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        lclk, prst_n, avl_n, ce_n, oe_n, we_n, wp_n, dq_oe, wait_pin, wait_oe;
    logic [7:0]  addr, a;
    logic [15:0] dq_in, dq_out, d, seen;
    int          bad_count = 0;
    int          n_compared = 0;
    int          exp_s[$];
    logic [15:0] exp_v[$];
    string       nm[4] = '{"dq", "dq_oe", "wait", "wait_oe"};
    always #4 clk_i = ~clk_i;
    flpb_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(lclk), .pin_reset_n_i(prst_n),
        .address_valid_n_i(avl_n), .die_select_n_i(ce_n), .die_output_enable_n_i(oe_n),
        .write_strobe_n_i(we_n), .write_protect_n_i(wp_n), .addr_i(addr), .dq_i(dq_in),
        .dq_o(dq_out), .dq_oe_o(dq_oe), .wait_o(wait_pin), .wait_oe_o(wait_oe));
    flpb_host u_host (.clk_i(clk_i), .dev_dq_i(dq_out), .dev_dq_oe_i(dq_oe),
        .link_clk_o(lclk),
        .pin_reset_n_o(prst_n), .address_valid_n_o(avl_n), .die_select_n_o(ce_n),
        .die_output_enable_n_o(oe_n), .write_strobe_n_o(we_n), .write_protect_n_o(wp_n),
        .addr_o(addr), .dq_bus_o(dq_in));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] w);
        n_compared++;
        if (s !== w) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, w, s);
        end
    endtask : check
    task automatic expect_out(input int s, input logic [15:0] v);
        exp_s.push_back(s);
        exp_v.push_back(v);
        @(negedge clk_i);
    endtask : expect_out
    task automatic test_done();
        if (bad_count == 0 && n_compared > 0 && exp_s.size() == 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // Monitor: looks just after the edge, once the registered outputs have settled
    always @(posedge clk_i) begin
        #1;
        if (exp_s.size() > 0) begin
            case (exp_s[0])
                0: seen = dq_out;
                1: seen = {15'h0, dq_oe};
                2: seen = {15'h0, wait_pin};
                default: seen = {15'h0, wait_oe};
            endcase
            check(nm[exp_s[0]], seen, exp_v[0]);
            void'(exp_s.pop_front());
            void'(exp_v.pop_front());
        end
    end
    initial begin
        #300000;
        bad_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'hb72eaff5));
        a = 8'($urandom % 64);
        d = 16'($urandom);
        repeat (3) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        expect_out(1, 16'h0);
        expect_out(3, 16'h0);
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_READ_CONFIG});
        u_host.rd(8'h00, 1'b0);
        expect_out(0, CFG0);
        expect_out(1, 16'h1);
        expect_out(3, 16'h1);
        expect_out(2, {15'h0, ~CFG0[`FLPB_CFG_WAIT_BIT]});
        u_host.rd(8'h00, 1'b1);
        expect_out(1, 16'h0);
        expect_out(3, 16'h0);
        u_host.wr(a, {8'h00, `FLPB_CMD_UNLOCK});
        u_host.wr(a, {8'h00, `FLPB_CMD_PROGRAM});
        u_host.wr(a, d);
        repeat (30) @(negedge clk_i);
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_READ_ARRAY});
        u_host.rd(a, 1'b0);
        expect_out(0, d);
        // Locked-down block refuses unlock while write-protect is low
        u_host.write_protect_n_o = 1'b0;
        u_host.wr(8'h40, {8'h00, `FLPB_CMD_LOCK_DOWN});
        u_host.wr(8'h40, {8'h00, `FLPB_CMD_UNLOCK});
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_READ_STATUS});
        u_host.rd(8'h00, 1'b0);
        expect_out(0, RDY | (16'h1 << `FLPB_STAT_LOCK_ERR_BIT));
        u_host.write_protect_n_o = 1'b1;
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_CLEAR_STATUS});
        u_host.wr(8'h40, {8'h00, `FLPB_CMD_UNLOCK});
        u_host.wr(8'h41, {8'h00, `FLPB_CMD_PROGRAM});
        u_host.wr(8'h41, ~d);
        repeat (30) @(negedge clk_i);
        u_host.rd(8'h00, 1'b0);
        expect_out(0, RDY);
        u_host.wr(8'hc0, {8'h00, `FLPB_CMD_PROGRAM});
        u_host.wr(8'hc0, d);
        repeat (30) @(negedge clk_i);
        u_host.rd(8'h00, 1'b0);
        expect_out(0, RDY | (16'h1 << `FLPB_STAT_PROG_ERR_BIT));
        // Writes during pin reset must leave the configuration alone
        u_host.pin_reset_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_SET_CONFIG});
        u_host.wr(8'h00, 16'h0000);
        u_host.pin_reset_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        u_host.rd(8'h41, 1'b0);
        expect_out(0, ~d);
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_READ_CONFIG});
        u_host.rd(8'h00, 1'b0);
        expect_out(0, CFG0);
        // Synchronous mode, wait active low, longest latency
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_SET_CONFIG});
        u_host.wr(8'h00, 16'h3800);
        u_host.wr(8'h00, {8'h00, `FLPB_CMD_READ_ARRAY});
        u_host.lk_run = 1'b1;
        u_host.address_valid_n_o = 1'b1;
        u_host.rd(a, 1'b0);
        u_host.address_valid_n_o = 1'b0;
        repeat (12) @(negedge clk_i);
        u_host.address_valid_n_o = 1'b1;
        u_host.rd(8'h41, 1'b0);
        expect_out(0, d);
        expect_out(2, 16'h1);
        // Link stopped: the core takes the last low address at the address-valid rise
        u_host.lk_run = 1'b0;
        u_host.address_valid_n_o = 1'b0;
        u_host.rd(8'h41, 1'b0);
        u_host.address_valid_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        expect_out(2, 16'h0);
        expect_out(0, ~d);
        test_done();
    end
endmodule : flash_parallel_bus_pins_bench
